// >>> logic/frc_top.v
// Fault response control: reaction registers, timing base and output enable
`timescale 1ns/1ps
`include "frc_map.vh"

// Behaviour
// - Retry setting 7 restarts without limit until the output is commanded off.
// - Unlimited retrying stops and latches when another fault shuts the unit down.
// - The 3-bit delay field counts time units for delayed operation or retry spacing.
// - Delay codes 0 to 7 select 1, 2, 4, 8, 16, 32, 64 and 128 time units.
// - The length of one time unit comes from the separate time unit register.
// - The input over-voltage threshold is a read/write 16-bit word.
// - The input over-voltage reaction is a read/write byte selecting the response.
// - Mode 00 keeps the output running when the fault is seen.
// - Mode 01 keeps running for the delay, then follows the retry setting if the fault stays.
// - Mode 10 disables the output at once and then follows the retry setting.
// - Mode 11 disables the output and holds it off until the fault is cleared.
// - A latched fault is released by its status bit clear, clear-faults, or reset.
// - A latched fault is released when the output is commanded off and then on again.
// - Retry setting 0 attempts no restart and keeps the output off until cleared.
// - Retry settings 1 to 6 give that many spaced restarts, then latch off if all fail.
module frc_top (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Command port
   input wire cmd_wr_i,
   input wire cmd_rd_i,
   input wire [7:0] cmd_code_i,
   input wire [15:0] cmd_wdata_i,
   output reg [15:0] cmd_rdata_o,
   output reg cmd_ack_o,
   // Sensing and on/off control
   input wire [15:0] vin_level_i,
   input wire ut_fault_i,
   input wire ctrl_pin_on_i,
   input wire operation_on_i,
   // Converter control and status
   output reg output_en_o,
   output reg ov_status_o,
   output reg ut_status_o
);

   reg [15:0] ov_threshold_r;
   reg [7:0] ov_reaction_r;
   reg [7:0] ut_reaction_r;
   reg [15:0] time_unit_r;
   reg [15:0] rdata_nxt;
   reg [3:0] div_r;
   reg tick_r;
   reg ov_fault_r;
   reg on_d_r;
   reg ov_stat_clr_r;
   reg ut_stat_clr_r;
   reg clear_all_r;
   wire on_now;
   wire on_rise;
   wire ov_dis;
   wire ut_dis;
   wire ov_latched;
   wire ut_latched;
   wire ov_release;
   wire ut_release;
   wire wr_ov_thr;
   wire wr_ov_react;
   wire wr_ut_react;
   wire wr_time_unit;
   wire wr_clear;
   wire wr_status;
   wire ov_over;
   wire ov_status_nxt;
   wire ut_status_nxt;
   wire output_en_nxt;

   localparam integer DIV_LAST = `FRC_MICRO_CYC - 1;

   // ----------------------------------------
   // Microsecond time base
   // ----------------------------------------
   // One shared tick keeps both sequencers on the same time grid
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         div_r <= 4'h0;
         tick_r <= 1'b0;
      end else if (div_r == DIV_LAST[3:0]) begin
         div_r <= 4'h0;
         tick_r <= 1'b1;
      end else begin
         div_r <= div_r + 4'h1;
         tick_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Command registers
   // ----------------------------------------
   // Decoded one access at a time: the host never raises both strobes together
   assign wr_ov_thr = cmd_wr_i && (cmd_code_i == `FRC_CMD_OV_THRESHOLD);
   assign wr_ov_react = cmd_wr_i && (cmd_code_i == `FRC_CMD_OV_REACTION);
   assign wr_ut_react = cmd_wr_i && (cmd_code_i == `FRC_CMD_UT_REACTION);
   assign wr_time_unit = cmd_wr_i && (cmd_code_i == `FRC_CMD_TIME_UNIT);
   assign wr_clear = cmd_wr_i && (cmd_code_i == `FRC_CMD_CLEAR_FAULTS);
   assign wr_status = cmd_wr_i && (cmd_code_i == `FRC_CMD_FAULT_STATUS);

   // Unmapped codes read as zero; no error is flagged to the host
   always @* begin
      case (cmd_code_i)
         `FRC_CMD_OV_THRESHOLD: rdata_nxt = ov_threshold_r;
         `FRC_CMD_OV_REACTION: rdata_nxt = {8'h00, ov_reaction_r};
         `FRC_CMD_UT_REACTION: rdata_nxt = {8'h00, ut_reaction_r};
         `FRC_CMD_TIME_UNIT: rdata_nxt = time_unit_r;
         `FRC_CMD_FAULT_STATUS: rdata_nxt = {14'h0, ut_status_o, ov_status_o};
         default: rdata_nxt = 16'h0000;
      endcase
   end

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         ov_threshold_r <= `FRC_RST_OV_THRESHOLD;
         ov_reaction_r <= `FRC_RST_REACTION;
         ut_reaction_r <= `FRC_RST_REACTION;
         time_unit_r <= `FRC_RST_TIME_UNIT;
         cmd_rdata_o <= 16'h0000;
         cmd_ack_o <= 1'b0;
         ov_stat_clr_r <= 1'b0;
         ut_stat_clr_r <= 1'b0;
         clear_all_r <= 1'b0;
      end else begin
         cmd_ack_o <= cmd_wr_i || cmd_rd_i;
         // Clears are registered so they act one edge after the write, like the ack
         clear_all_r <= wr_clear;
         ov_stat_clr_r <= wr_status && cmd_wdata_i[`FRC_STAT_OV_BIT];
         ut_stat_clr_r <= wr_status && cmd_wdata_i[`FRC_STAT_UT_BIT];
         if (wr_ov_thr)
            ov_threshold_r <= cmd_wdata_i;
         if (wr_ov_react)
            ov_reaction_r <= cmd_wdata_i[7:0];
         if (wr_ut_react)
            ut_reaction_r <= cmd_wdata_i[7:0];
         if (wr_time_unit)
            time_unit_r <= cmd_wdata_i;
         // Read data stands until the next read, so a slow host may fetch it late
         if (cmd_rd_i)
            cmd_rdata_o <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Fault detection and release sources
   // ----------------------------------------
   // Raw compare: threshold and level must share one linear exponent
   assign ov_over = (vin_level_i > ov_threshold_r);
   assign on_now = ctrl_pin_on_i && operation_on_i;
   assign on_rise = on_now && !on_d_r;
   assign ov_release = clear_all_r || ov_stat_clr_r || on_rise;
   assign ut_release = clear_all_r || ut_stat_clr_r || on_rise;
   // Set wins over a clear in the same cycle
   assign ov_status_nxt = ov_fault_r || (ov_status_o && !(ov_stat_clr_r || clear_all_r));
   assign ut_status_nxt = ut_fault_i || (ut_status_o && !(ut_stat_clr_r || clear_all_r));
   // Either sequencer may hold the output off; neither can force it on
   assign output_en_nxt = on_now && !ov_dis && !ut_dis;

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         ov_fault_r <= 1'b0;
         // Idle level of the on command, so leaving reset is no off-to-on edge
         on_d_r <= 1'b1;
         ov_status_o <= 1'b0;
         ut_status_o <= 1'b0;
         output_en_o <= 1'b0;
      end else begin
         ov_fault_r <= ov_over;
         on_d_r <= on_now;
         ov_status_o <= ov_status_nxt;
         ut_status_o <= ut_status_nxt;
         output_en_o <= output_en_nxt;
      end
   end

   // ----------------------------------------
   // Reaction sequencers
   // ----------------------------------------
   // Each sequencer sees the other's latch as the shutdown that ends endless retries
   frc_engine #(.TW(16)) u_ov (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .tick_i(tick_r),
      .unit_i(time_unit_r),
      .fault_i(ov_fault_r),
      .reaction_i(ov_reaction_r),
      .release_i(ov_release),
      .on_i(on_now),
      .other_off_i(ut_latched),
      .disable_o(ov_dis),
      .latched_o(ov_latched)
   );

   frc_engine #(.TW(16)) u_ut (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .tick_i(tick_r),
      .unit_i(time_unit_r),
      .fault_i(ut_fault_i),
      .reaction_i(ut_reaction_r),
      .release_i(ut_release),
      .on_i(on_now),
      .other_off_i(ov_latched),
      .disable_o(ut_dis),
      .latched_o(ut_latched)
   );

endmodule

// >>> logic/frc_map.vh
// Command codes, field positions, reset values and timing counts of the fault response block
`ifndef FRC_MAP_VH
`define FRC_MAP_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define FRC_CMD_CLEAR_FAULTS 8'h03
`define FRC_CMD_UT_REACTION 8'h54
`define FRC_CMD_OV_THRESHOLD 8'h55
`define FRC_CMD_OV_REACTION 8'h56
`define FRC_CMD_TIME_UNIT 8'hD2
`define FRC_CMD_FAULT_STATUS 8'hE0

// ----------------------------------------
// Reaction byte fields
// ----------------------------------------
`define FRC_MODE_HI 7
`define FRC_MODE_LO 6
`define FRC_RETRY_HI 5
`define FRC_RETRY_LO 3
`define FRC_DELAY_HI 2
`define FRC_DELAY_LO 0
`define FRC_MODE_IGNORE 2'h0
`define FRC_MODE_DELAYED 2'h1
`define FRC_MODE_RETRY 2'h2
`define FRC_MODE_LATCH 2'h3
`define FRC_RETRY_NONE 3'h0
`define FRC_RETRY_FOREVER 3'h7

// ----------------------------------------
// Status register bits
// ----------------------------------------
`define FRC_STAT_OV_BIT 0
`define FRC_STAT_UT_BIT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FRC_RST_OV_THRESHOLD 16'hFFFF
`define FRC_RST_REACTION 8'h80
`define FRC_RST_TIME_UNIT 16'h03E8

// ----------------------------------------
// Timing: time unit register counts microseconds
// ----------------------------------------
`define FRC_CLK_PERIOD_NS 100
`define FRC_MICRO_NS 1000
`define FRC_MICRO_CYC (`FRC_MICRO_NS / `FRC_CLK_PERIOD_NS)

`endif

// >>> logic/frc_engine.v
// One fault reaction sequencer: ignore, delayed, retrying or latching response
`timescale 1ns/1ps
`include "frc_map.vh"

module frc_engine #(
   parameter TW = 16
) (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Timing
   input wire tick_i,
   input wire [TW-1:0] unit_i,
   // Fault and control
   input wire fault_i,
   input wire [7:0] reaction_i,
   input wire release_i,
   input wire on_i,
   input wire other_off_i,
   // State
   output wire disable_o,
   output wire latched_o
);

   localparam S_IDLE = 3'h0;
   localparam S_DELAY = 3'h1;
   localparam S_WAIT = 3'h2;
   localparam S_TRY = 3'h3;
   localparam S_LATCH = 3'h4;
   localparam CW = TW + 8;

   reg [2:0] state_r;
   reg [7:0] react_r;
   reg [2:0] left_r;
   reg [CW-1:0] cnt_r;
   wire [CW-1:0] target;
   wire [CW-1:0] cnt_inc;
   wire timer_done;
   wire forever_mode;
   wire [2:0] retries;

   // Interval length in microseconds = unit length times 2**code
   assign target = {8'h00, unit_i} << react_r[`FRC_DELAY_HI:`FRC_DELAY_LO];
   assign cnt_inc = cnt_r + {{(CW-1){1'b0}}, 1'b1};
   assign timer_done = tick_i && (cnt_inc >= target);
   assign retries = react_r[`FRC_RETRY_HI:`FRC_RETRY_LO];
   assign forever_mode = (retries == `FRC_RETRY_FOREVER);

   assign disable_o = (state_r == S_WAIT) || (state_r == S_LATCH);
   assign latched_o = (state_r == S_LATCH);

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         state_r <= S_IDLE;
         react_r <= 8'h00;
         left_r <= 3'h0;
         cnt_r <= {CW{1'b0}};
      end else if (release_i && state_r != S_IDLE) begin
         state_r <= S_IDLE;
      end else begin
         if (tick_i)
            cnt_r <= cnt_inc;
         case (state_r)
            S_IDLE: begin
               cnt_r <= {CW{1'b0}};
               // Snapshot so a later write cannot bend a running sequence
               react_r <= reaction_i;
               if (fault_i) begin
                  case (reaction_i[`FRC_MODE_HI:`FRC_MODE_LO])
                     `FRC_MODE_DELAYED: state_r <= S_DELAY;
                     `FRC_MODE_RETRY: begin
                        if (reaction_i[`FRC_RETRY_HI:`FRC_RETRY_LO] == `FRC_RETRY_NONE)
                           state_r <= S_LATCH;
                        else
                           state_r <= S_WAIT;
                        left_r <= reaction_i[`FRC_RETRY_HI:`FRC_RETRY_LO];
                     end
                     `FRC_MODE_LATCH: state_r <= S_LATCH;
                     default: state_r <= S_IDLE;
                  endcase
               end
            end
            S_DELAY: begin
               if (timer_done) begin
                  cnt_r <= {CW{1'b0}};
                  left_r <= retries;
                  if (!fault_i)
                     state_r <= S_IDLE;
                  else if (retries == `FRC_RETRY_NONE)
                     state_r <= S_LATCH;
                  else
                     state_r <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (forever_mode && other_off_i)
                  state_r <= S_LATCH;
               else if (forever_mode && !on_i)
                  state_r <= S_IDLE;
               else if (timer_done) begin
                  cnt_r <= {CW{1'b0}};
                  state_r <= S_TRY;
               end
            end
            S_TRY: begin
               // Output released for one cycle, then the fault is sampled
               cnt_r <= {CW{1'b0}};
               if (!fault_i)
                  state_r <= S_IDLE;
               else if (forever_mode) begin
                  state_r <= other_off_i ? S_LATCH : S_WAIT;
               end else if (left_r > 3'h1) begin
                  left_r <= left_r - 3'h1;
                  state_r <= S_WAIT;
               end else
                  state_r <= S_LATCH;
            end
            S_LATCH: state_r <= S_LATCH;
            default: state_r <= S_IDLE;
         endcase
      end
   end

endmodule

// >>> verif/frc_host_model.sv
// Host model that drives the command port of the fault response block
`timescale 1ns/1ps
module frc_host (
   // Clock
   input wire logic clk_i,
   // Command port
   output logic cmd_wr_o,
   output logic cmd_rd_o,
   output logic [7:0] cmd_code_o,
   output logic [15:0] cmd_wdata_o,
   input wire logic [15:0] cmd_rdata_i,
   input wire logic cmd_ack_i
);
   initial begin
      cmd_wr_o = 1'h0;
      cmd_rd_o = 1'h0;
      cmd_code_o = 8'h00;
      cmd_wdata_o = 16'h0000;
   end

   // ---------------------------------
   // One strobe, answer taken one cycle later
   // ---------------------------------
   task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
      output logic [15:0] q);
      @(negedge clk_i);
      cmd_wr_o = w;
      cmd_rd_o = !w;
      cmd_code_o = c;
      cmd_wdata_o = d;
      @(negedge clk_i);
      cmd_wr_o = 1'h0;
      cmd_rd_o = 1'h0;
      // Stale values would hide a design that samples late
      cmd_code_o = ~c;
      cmd_wdata_o = ~d;
      q = cmd_ack_i ? cmd_rdata_i : 16'hXXXX;
   endtask
endmodule

// >>> verif/frc_top_checker.sv
// Port assertions for the fault response block
`timescale 1ns/1ps
module frc_top_checker (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Command port
   input wire cmd_wr_i,
   input wire cmd_rd_i,
   input wire [7:0] cmd_code_i,
   input wire [15:0] cmd_wdata_i,
   input wire [15:0] cmd_rdata_o,
   input wire cmd_ack_o,
   // Control and status
   input wire ut_fault_i,
   input wire ctrl_pin_on_i,
   input wire operation_on_i,
   input wire output_en_o,
   input wire ov_status_o,
   input wire ut_status_o
);
   reg [15:0] thr_r;
   reg [7:0] ovr_r;
   wire clr_w = cmd_wr_i && (cmd_code_i == 8'h03 || cmd_code_i == 8'hE0);
   wire hole_w = !(cmd_code_i inside {8'h03, 8'h54, 8'h55, 8'h56, 8'hD2, 8'hE0});

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         thr_r <= 16'hFFFF;
         ovr_r <= 8'h80;
      end else if (cmd_wr_i && cmd_code_i == 8'h55) begin
         thr_r <= cmd_wdata_i;
      end else if (cmd_wr_i && cmd_code_i == 8'h56) begin
         ovr_r <= cmd_wdata_i[7:0];
      end
   end

   // ---------------------------------
   // Properties
   // ---------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   AST_ACK: assert property (cmd_ack_o == $past(cmd_wr_i | cmd_rd_i))
      else $error("ack not one cycle after strobe");
   AST_RD_THR: assert property (cmd_rd_i && cmd_code_i == 8'h55 |=> cmd_rdata_o == thr_r)
      else $error("threshold readback wrong");
   AST_RD_REAC: assert property (cmd_rd_i && cmd_code_i == 8'h56 |=>
      cmd_rdata_o == {8'h00, ovr_r}) else $error("reaction readback wrong");
   AST_RD_HOLE: assert property (cmd_rd_i && hole_w |=> cmd_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   AST_OFF: assert property (!(ctrl_pin_on_i && operation_on_i) [*3] |-> !output_en_o)
      else $error("output on while commanded off");
   AST_OV_CLR: assert property ($fell(ov_status_o) |->
      $past(clr_w) || $past(clr_w, 2) || $past(clr_w, 3)) else $error("ov status lost");
   AST_UT_CLR: assert property ($fell(ut_status_o) |->
      $past(clr_w) || $past(clr_w, 2) || $past(clr_w, 3)) else $error("ut status lost");
   AST_UT_SET: assert property ($rose(ut_fault_i) |-> ##[1:2] ut_status_o)
      else $error("ut status not set");
   cover property ($fell(output_en_o));
   cover property ($fell(ov_status_o));
   cover property (cmd_rd_i && cmd_code_i == 8'h55 ##1 cmd_ack_o);
endmodule

bind frc_top frc_top_checker u_frc_top_checker (.clk_i, .nrst_i, .cmd_wr_i, .cmd_rd_i,
   .cmd_code_i, .cmd_wdata_i, .cmd_rdata_o, .cmd_ack_o, .ut_fault_i, .ctrl_pin_on_i,
   .operation_on_i, .output_en_o, .ov_status_o, .ut_status_o);

// >>> verif/tb_fault_response_control.sv
// Self-checking bench for the fault response block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_fault_response_control;
   logic clk_i = 1'h0;
   logic nrst_i = 1'h0;
   logic wr, rd, ack, en, ovs, uts;
   logic ut = 1'h0;
   logic cp = 1'h1;
   logic op = 1'h1;
   logic [7:0] code;
   logic [15:0] wd, q;
   logic [15:0] vin = 16'h0000;
   int tests_run = 0;
   int fail_count = 0;

   frc_host u_frc_host (.clk_i, .cmd_wr_o(wr), .cmd_rd_o(rd), .cmd_code_o(code),
      .cmd_wdata_o(wd), .cmd_rdata_i(q), .cmd_ack_i(ack));
   frc_top u_frc_top (.clk_i, .nrst_i, .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_code_i(code),
      .cmd_wdata_i(wd), .cmd_rdata_o(q), .cmd_ack_o(ack), .vin_level_i(vin),
      .ut_fault_i(ut), .ctrl_pin_on_i(cp), .operation_on_i(op), .output_en_o(en),
      .ov_status_o(ovs), .ut_status_o(uts));

   // ---------------------------------
   // Helpers
   // ---------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wrc(input logic [7:0] c, input logic [15:0] d);
      logic [15:0] x;
      u_frc_host.acc(1'h1, c, d, x);
   endtask
   task automatic rdc(input logic [7:0] c, input logic [15:0] e);
      logic [15:0] x;
      u_frc_host.acc(1'h0, c, 16'h0000, x);
      `CHK("readback", e, x)
   endtask
   // Delay in cycles with a time unit of one microsecond
   function automatic int span(input int c);
      return 10 << c;
   endfunction
   task automatic rises(input int n, output int k);
      logic p;
      k = 0;
      p = en;
      repeat (n) begin
         cyc(1);
         if (en === 1'h1 && p !== 1'h1) k++;
         p = en;
      end
   endtask
   task automatic settle();
      vin = 16'h0000;
      ut = 1'h0;
      wrc(8'h03, 16'h0000);
      cyc(8);
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ---------------------------------
   // Clock, watchdog and tests
   // ---------------------------------
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // The tests need under 8000 cycles; a hang is cut at 20000
   initial begin
      #2000000;
      fail_count++;
      summarize();
   end
   initial begin
      int k;
      logic [15:0] r;
      k = $urandom(32'h56fd);
      cyc(16);
      nrst_i = 1'h1;
      rdc(8'h55, 16'hFFFF);
      rdc(8'h56, 16'h0080);
      rdc(8'h77, 16'h0000);
      r = $urandom;
      wrc(8'h55, r);
      rdc(8'h55, r);
      wrc(8'h56, r);
      rdc(8'h56, {8'h00, r[7:0]});
      wrc(8'h54, ~r);
      rdc(8'h54, {8'h00, ~r[7:0]});
      wrc(8'hD2, 16'h0001);
      rdc(8'hD2, 16'h0001);
      wrc(8'h55, 16'h1000);
      $display("test registers done");
      wrc(8'h56, 16'h00C0);
      for (int j = 0; j < 5; j++) begin
         vin = 16'h1001;
         cyc(3);
         `CHK("latch", 1'h0, en)
         vin = 16'h1000;
         cyc(30);
         `CHK("held", 1'h0, en)
         if (j == 0) wrc(8'hE0, 16'h0001);
         else if (j == 1) wrc(8'h03, 16'h0000);
         else if (j == 2) begin
            cp = 1'h0;
            cyc(4);
            cp = 1'h1;
         end else if (j == 3) begin
            op = 1'h0;
            cyc(4);
            op = 1'h1;
         end else begin
            nrst_i = 1'h0;
            cyc(4);
            `CHK("in reset", 2'h0, {en, ovs})
            nrst_i = 1'h1;
         end
         cyc(6);
         `CHK("release", 1'h1, en)
      end
      rdc(8'h55, 16'hFFFF);
      rdc(8'hD2, 16'h03E8);
      rdc(8'h54, 16'h0080);
      wrc(8'hD2, 16'h0001);
      wrc(8'h55, 16'h1000);
      $display("test latch done");
      wrc(8'h56, 16'h0000);
      vin = 16'hFFFF;
      cyc(40);
      `CHK("ignore", 2'h3, {en, ovs})
      rdc(8'hE0, 16'h0001);
      settle();
      for (int d = 0; d < 8; d++) begin
         wrc(8'h56, 16'h0040 + d);
         vin = 16'h2000;
         k = 0;
         while (en === 1'h1 && k < 1400) begin
            cyc(1);
            k++;
         end
         `CHK("delay", 1'h1, k >= span(d) - 10 && k <= span(d) + 12)
         settle();
      end
      $display("test delay done");
      for (int n = 0; n < 7; n++) begin
         wrc(8'h56, 16'h0080 + (n << 3));
         vin = 16'h2000;
         rises(300, k);
         `CHK("retries", n, k)
         settle();
      end
      $display("test retry done");
      wrc(8'h56, 16'h00B8);
      vin = 16'h2000;
      rises(200, k);
      `CHK("forever", 1'h1, k > 10)
      ut = 1'h1;
      cyc(5);
      `CHK("ut status", 1'h1, uts)
      ut = 1'h0;
      rdc(8'hE0, 16'h0003);
      wrc(8'hE0, 16'h0002);
      rises(200, k);
      `CHK("stopped", 0, k)
      rdc(8'hE0, 16'h0001);
      settle();
      $display("test other fault done");
      summarize();
   end
endmodule
